// file: core/run_halt_console_control.sv
// Processor run/halt, machine reset and console control with APB access.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "run_halt_regs.svh"
module run_halt_console_control
	import run_halt_pkg::*;
#(
	parameter int PWRON_CYCLES = `PWRON_TIME_MS * `CLK_KHZ,
	parameter int DEBOUNCE_CYCLES = `DEBOUNCE_TIME_US * `CLK_KHZ / 1000
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic irq_o,
	input wire logic sw_run_i,
	input wire logic sw_step_i,
	input wire logic sw_intr_i,
	input wire logic sw_clock_i,
	input wire logic sw_reset_i,
	input wire logic sw_save_i,
	input wire logic sw_panel_i,
	input wire logic [3:0] sw_sense_i,
	input wire logic [6:0] sw_display_i,
	input wire logic [15:0] sw_cmd_i,
	input wire logic power_fail_i,
	input wire logic [`RTC_DIV_W-1:0] rtc_div_i,
	input wire logic [15:0] rom_data_i,
	input wire logic [15:0] cmd_reg_i,
	input wire logic [11:0] l_reg_i,
	input wire logic [7:0] m_reg_i,
	input wire logic [7:0] n_reg_i,
	input wire logic [7:0] abus_i,
	input wire logic exec_valid_i,
	input wire logic [15:0] exec_cmd_i,
	input wire logic cmd_done_i,
	input wire logic halt_req_i,
	input wire logic [7:0] istat_ack_i,
	input wire logic [1:0] flag_ack_i,
	output logic run_o,
	output logic run_lamp_o,
	output logic halt_lamp_o,
	output logic machine_reset_o,
	output logic io_reset_o,
	output logic [15:0] cmd_o,
	output logic [11:0] display_o,
	output logic [7:0] istat_o,
	output logic flag_int_o,
	output logic flag_pf_o,
	output logic [3:0] sense_o,
	output logic sense_load_o
);
	localparam int PW_W = $clog2(PWRON_CYCLES + 1);
	localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam logic [PW_W-1:0] PW_MAX = PW_W'(PWRON_CYCLES - 1);
	localparam logic [DB_W-1:0] DB_MAX = DB_W'(DEBOUNCE_CYCLES - 1);

	if (PWRON_CYCLES < 2 || DEBOUNCE_CYCLES < 1) begin : g_check
		$error("Timing counts too small for the control logic.");
	end

	function automatic logic is_cmd(input logic [15:0] c,
		input logic [15:0] code);
		is_cmd = exec_valid_i && (c == code);
	endfunction

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Switch synchronisers and debouncers.
	logic [`SW_COUNT-1:0] sw_raw;
	logic [`SW_COUNT-1:0] swd;
	assign sw_raw = {sw_cmd_i, sw_display_i, sw_sense_i, sw_panel_i,
		sw_save_i, sw_reset_i, sw_clock_i, sw_intr_i, sw_step_i, sw_run_i};

	genvar g;
	for (g = 0; g < `SW_COUNT; g++) begin : g_db
		logic s1_reg;
		logic s2_reg;
		logic db_reg;
		logic db_next;
		logic [DB_W-1:0] cnt_reg;
		logic [DB_W-1:0] cnt_next;
		always_comb begin
			db_next = db_reg;
			cnt_next = cnt_reg;
			if (s2_reg == db_reg) begin
				cnt_next = '0;
			end else if (cnt_reg == DB_MAX) begin
				db_next = s2_reg; // R19
				cnt_next = '0;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
		always_ff @(posedge clk_sys_i) begin
			if (rst_i) begin
				s1_reg <= 1'b0;
				s2_reg <= 1'b0;
				db_reg <= 1'b0;
				cnt_reg <= '0;
			end else if (ce_i) begin
				s1_reg <= sw_raw[g]; // R19
				s2_reg <= s1_reg;
				db_reg <= db_next;
				cnt_reg <= cnt_next;
			end
		end
		assign swd[g] = db_reg;
	end

	// Run state, interrupts and console outputs.
	run_state_t state_reg, state_next;
	logic [`SW_COUNT-1:0] swp_reg;
	logic [PW_W-1:0] pw_cnt_reg, pw_cnt_next;
	logic [`RTC_DIV_W-1:0] rtc_cnt_reg, rtc_cnt_next;
	logic rtc_en_reg, rtc_en_next;
	logic pf_seen_reg, pf_seen_next;
	logic pf_prev_reg;
	logic [7:0] istat_reg, istat_next;
	logic flag4_reg, flag4_next;
	logic flag5_reg, flag5_next;
	logic mreset_next;
	logic running_next;
	logic [11:0] disp_next;
	logic [15:0] cmd_next;
	logic rtc_tick;
	logic restart_ev;
	logic pf_ev;
	logic halted_ev;
	logic press_run, press_intr, press_clock;
	logic hold_step, hold_reset;
	logic [`EV_W-1:0] ev;

	logic [`EV_W-1:0] irq_stat_reg, irq_stat_next;
	logic [`EV_W-1:0] irq_en_reg, irq_en_next;
	logic irq_next;
	logic [31:0] prdata_next;
	logic pready_next;
	logic pslverr_next;
	logic wr_ctrl;
	logic [`EV_W-1:0] clr_bits;

	always_comb begin
		press_run = swd[`SW_RUN] && !swp_reg[`SW_RUN];
		press_intr = swd[`SW_INTR] && !swp_reg[`SW_INTR];
		press_clock = swd[`SW_CLOCK] && !swp_reg[`SW_CLOCK];
		hold_step = swd[`SW_STEP];
		hold_reset = swd[`SW_RESET] || swd[`SW_SAVE]; // R17 R18
		state_next = state_reg;
		pw_cnt_next = pw_cnt_reg;
		restart_ev = 1'b0;
		unique case (state_reg)
			ST_PWRON: begin
				if (pw_cnt_reg == PW_MAX) begin
					state_next = ST_RUN; // R06 R07
					restart_ev = 1'b1; // R07
				end else begin
					pw_cnt_next = pw_cnt_reg + 1'b1;
				end
			end
			ST_HALT: begin
				if (press_run || press_intr || hold_step) begin
					state_next = ST_RUN; // R13 R14 R15
				end else if (press_clock) begin
					state_next = ST_SINGLE; // R16
				end
			end
			ST_RUN: begin
				if (press_clock) begin
					state_next = ST_STOP; // R16
				end else if (halt_req_i && !hold_step && !press_intr) begin
					state_next = ST_HALT;
				end
			end
			ST_SINGLE, ST_STOP: begin
				if (cmd_done_i) begin
					state_next = ST_HALT; // R16
				end
			end
		endcase
		if (state_reg != ST_PWRON && hold_reset) begin
			state_next = ST_HALT; // R17 R18
		end
		running_next = (state_next != ST_HALT) && (state_next != ST_PWRON);
		halted_ev = (state_next == ST_HALT) && (state_reg != ST_HALT);

		pf_ev = power_fail_i && !pf_prev_reg;
		pf_seen_next = pf_seen_reg || power_fail_i;
		mreset_next = (state_next == ST_PWRON) || hold_reset
			|| (pf_seen_next && state_next == ST_HALT); // R05 R06 R08 R17

		rtc_en_next = rtc_en_reg;
		if (wr_ctrl) begin
			rtc_en_next = pwdata_i[`CTRL_RTC_EN];
		end
		if (is_cmd(exec_cmd_i, `CMD_RTC_OFF)) begin
			rtc_en_next = 1'b0; // R03
		end else if (is_cmd(exec_cmd_i, `CMD_RTC_ON)) begin
			rtc_en_next = 1'b1; // R03
		end
		rtc_tick = 1'b0;
		if (rtc_cnt_reg + 1'b1 >= rtc_div_i) begin
			rtc_cnt_next = '0;
			rtc_tick = rtc_en_reg; // R01
		end else begin
			rtc_cnt_next = rtc_cnt_reg + 1'b1; // R01
		end

		istat_next = istat_reg & ~istat_ack_i;
		flag4_next = flag4_reg && !flag_ack_i[0];
		flag5_next = flag5_reg && !flag_ack_i[1];
		if (rtc_tick) begin
			istat_next[`ISTAT_RTC] = 1'b1; // R02
			flag4_next = 1'b1; // R02
		end
		if (pf_ev || restart_ev) begin
			istat_next[`ISTAT_HALT] = 1'b1; // R04 R07
			flag5_next = 1'b1; // R04 R07
		end
		if (hold_step) begin
			istat_next[`ISTAT_HALT] = 1'b1; // R14
		end
		if (press_intr) begin
			istat_next[`ISTAT_CONSOLE] = 1'b1; // R15
		end

		if (swd[`SW_PANEL]) begin
			cmd_next = swd[`SW_CMD_LO +: 16]; // R11
		end else begin
			cmd_next = rom_data_i;
		end
		disp_next = '0;
		if (swd[`SW_DISP_LO + `DISP_L]) begin
			disp_next = l_reg_i; // R10
		end else if (swd[`SW_DISP_LO + `DISP_M]) begin
			disp_next = {4'h0, m_reg_i};
		end else if (swd[`SW_DISP_LO + `DISP_N]) begin
			disp_next = {4'h0, n_reg_i};
		end else if (swd[`SW_DISP_LO + `DISP_ROM_HI]) begin
			disp_next = {4'h0, cmd_reg_i[15:8]}; // R10
		end else if (swd[`SW_DISP_LO + `DISP_ROM_LO]) begin
			disp_next = {4'h0, cmd_reg_i[7:0]}; // R10
		end else if (swd[`SW_DISP_LO + `DISP_ABUS]) begin
			disp_next = {4'h0, abus_i};
		end
		ev = '0;
		ev[`EV_RTC] = rtc_tick;
		ev[`EV_PFAIL] = pf_ev;
		ev[`EV_RESTART] = restart_ev;
		ev[`EV_CONSOLE] = press_intr;
		ev[`EV_HALTED] = halted_ev;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= ST_PWRON;
			swp_reg <= '0;
			pw_cnt_reg <= '0;
			rtc_cnt_reg <= '0;
			rtc_en_reg <= 1'b1;
			pf_seen_reg <= 1'b0;
			pf_prev_reg <= 1'b0;
			istat_reg <= '0;
			flag4_reg <= 1'b0;
			flag5_reg <= 1'b0;
			run_o <= 1'b0;
			run_lamp_o <= 1'b0;
			halt_lamp_o <= 1'b1;
			machine_reset_o <= 1'b1;
			io_reset_o <= 1'b1;
			cmd_o <= '0;
			display_o <= '0;
			istat_o <= '0;
			flag_int_o <= 1'b0;
			flag_pf_o <= 1'b0;
			sense_o <= '0;
			sense_load_o <= 1'b0;
		end else if (ce_i) begin
			state_reg <= state_next;
			swp_reg <= swd;
			pw_cnt_reg <= pw_cnt_next;
			rtc_cnt_reg <= rtc_cnt_next;
			rtc_en_reg <= rtc_en_next;
			pf_seen_reg <= pf_seen_next;
			pf_prev_reg <= power_fail_i;
			istat_reg <= istat_next;
			flag4_reg <= flag4_next;
			flag5_reg <= flag5_next;
			run_o <= running_next;
			run_lamp_o <= running_next; // R09
			halt_lamp_o <= !running_next; // R09
			machine_reset_o <= mreset_next; // R08
			io_reset_o <= mreset_next; // R17
			cmd_o <= cmd_next;
			display_o <= disp_next;
			istat_o <= istat_next;
			flag_int_o <= flag4_next;
			flag_pf_o <= flag5_next;
			sense_o <= swd[`SW_SENSE_LO +: 4]; // R12
			sense_load_o <= is_cmd(exec_cmd_i, `CMD_SENSE); // R12
		end
	end

	// APB slave and interrupt registers.
	always_comb begin
		wr_ctrl = psel_i && penable_i && !pready_o && pwrite_i
			&& hit(paddr_i, `REG_CTRL);
		clr_bits = '0;
		irq_en_next = irq_en_reg;
		prdata_next = '0;
		pslverr_next = 1'b0;
		pready_next = psel_i && penable_i && !pready_o;
		if (pready_next) begin
			if (hit(paddr_i, `REG_CTRL)) begin
				prdata_next[`CTRL_RTC_EN] = rtc_en_reg;
			end else if (hit(paddr_i, `REG_STATE)) begin
				prdata_next[`ST_FLD_LO +: 5] = state_reg;
				prdata_next[`ST_MRESET] = machine_reset_o;
				prdata_next[`ST_PFAIL] = pf_seen_reg;
				prdata_next[`ST_ISTAT_LO +: 8] = istat_reg;
				prdata_next[`ST_FLAG4] = flag4_reg;
				prdata_next[`ST_FLAG5] = flag5_reg;
				pslverr_next = pwrite_i;
			end else if (hit(paddr_i, `REG_IRQ_STAT)) begin
				prdata_next[`EV_W-1:0] = irq_stat_reg;
				pslverr_next = pwrite_i;
			end else if (hit(paddr_i, `REG_IRQ_CLR)) begin
				if (pwrite_i) begin
					clr_bits = pwdata_i[`EV_W-1:0];
				end
			end else if (hit(paddr_i, `REG_IRQ_EN)) begin
				prdata_next[`EV_W-1:0] = irq_en_reg;
				if (pwrite_i) begin
					irq_en_next = pwdata_i[`EV_W-1:0];
				end
			end else begin
				pslverr_next = 1'b1;
			end
		end
		irq_stat_next = (irq_stat_reg & ~clr_bits) | ev;
		irq_next = |(irq_stat_next & irq_en_next);
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
			irq_en_reg <= '0;
			irq_o <= 1'b0;
			prdata_o <= '0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			irq_stat_reg <= irq_stat_next;
			irq_en_reg <= irq_en_next;
			irq_o <= irq_next;
			prdata_o <= prdata_next;
			pready_o <= pready_next;
			pslverr_o <= pslverr_next;
		end
	end
endmodule

// file: core/run_halt_pkg.sv
// Types shared by the run/halt console control block.
package run_halt_pkg;
	typedef enum logic [4:0] {
		ST_PWRON = 5'b00001,
		ST_HALT = 5'b00010,
		ST_RUN = 5'b00100,
		ST_SINGLE = 5'b01000,
		ST_STOP = 5'b10000
	} run_state_t;
endpackage

// file: core/run_halt_regs.svh
// Constants and register map of the run/halt console control block.
// What this block does
// R01: RTC tick divides clock by strapped divisor.
// R02: RTC tick sets flag 4, status 2.
// R03: Command 1710 disables, 1720 enables RTC.
// R04: Power loss sets flag 5, status 7.
// R05: Halted after power loss asserts machine reset.
// R06: Machine reset held 200 ms at power-on.
// R07: After power-on reset: run and restart interrupt in the same cycle.
// R08: Machine reset clears microinstruction address register.
// R09: Run lamp while running, halt lamp otherwise.
// R10: Six selectors choose display; no selection shows zero.
// R11: Panel select uses switches as command source.
// R12: Control command copies four sense switches.
// R13: Run switch enters continuous run mode.
// R14: Step held forces run, sets status 7.
// R15: Interrupt switch forces run, sets status 0.
// R16: Clock switch executes one microcommand, then halts.
// R17: Reset switch halts at once, resets everything.
// R18: Save switch holds reset while on.
// R19: Console switches synchronised and debounced first.
`ifndef RUN_HALT_REGS_SVH
`define RUN_HALT_REGS_SVH

`define CLK_KHZ 125000
`define PWRON_TIME_MS 200
`define DEBOUNCE_TIME_US 1000
`define RTC_DIV_W 13

`define CMD_RTC_OFF 16'h1710
`define CMD_RTC_ON 16'h1720
`define CMD_SENSE 16'h7010

`define ISTAT_CONSOLE 0
`define ISTAT_RTC 2
`define ISTAT_HALT 7

`define SW_RUN 0
`define SW_STEP 1
`define SW_INTR 2
`define SW_CLOCK 3
`define SW_RESET 4
`define SW_SAVE 5
`define SW_PANEL 6
`define SW_SENSE_LO 7
`define SW_DISP_LO 11
`define SW_CMD_LO 18
`define SW_COUNT 34

`define DISP_L 0
`define DISP_M 1
`define DISP_N 2
`define DISP_ROM_HI 3
`define DISP_ROM_LO 4
`define DISP_ABUS 5

`define REG_CTRL 8'h00
`define REG_STATE 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_CLR 8'h0c
`define REG_IRQ_EN 8'h10

`define CTRL_RTC_EN 0
`define EV_RTC 0
`define EV_PFAIL 1
`define EV_RESTART 2
`define EV_CONSOLE 3
`define EV_HALTED 4
`define EV_W 5

`define ST_FLD_LO 0
`define ST_MRESET 5
`define ST_PFAIL 6
`define ST_ISTAT_LO 8
`define ST_FLAG4 16
`define ST_FLAG5 17

`endif

// file: tb/console_model.sv
// Operator console and power monitor that drive the switch levels.
`timescale 1ns/100ps
module console_model (
	input wire logic clk_i,
	output logic [7:0] sw_o
);
	// Bit 7 stands for loss of primary power.
	initial sw_o = 8'h00;
	task tap(input int b);
		@(posedge clk_i);
		sw_o[b] <= 1'b1;
		@(posedge clk_i);
		sw_o[b] <= 1'b0;
	endtask
	// A momentary press bounces once before its contact settles.
	task press(input int b, input int k);
		tap(b);
		repeat (2) @(posedge clk_i);
		sw_o[b] <= 1'b1;
		repeat (k) @(posedge clk_i);
		sw_o[b] <= 1'b0;
	endtask
	task set_sw(input int b, input logic v);
		@(posedge clk_i);
		sw_o[b] <= v;
	endtask
endmodule

// file: tb/run_halt_monitor.sv
// Concurrent checks on the run/halt console control ports.
`timescale 1ns/100ps
`include "run_halt_regs.svh"
module run_halt_monitor #(
	parameter int PWRON_CYCLES = 20
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sw_step_i,
	input wire logic sw_reset_i,
	input wire logic exec_valid_i,
	input wire logic [15:0] exec_cmd_i,
	input wire logic run_o,
	input wire logic run_lamp_o,
	input wire logic halt_lamp_o,
	input wire logic machine_reset_o,
	input wire logic io_reset_o,
	input wire logic [7:0] istat_o,
	input wire logic flag_int_o,
	input wire logic flag_pf_o,
	input wire logic sense_load_o
);
	localparam int PW_HI = PWRON_CYCLES + 8;
	wire sense_cmd = exec_valid_i && exec_cmd_i == `CMD_SENSE;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	chk_lamps_follow: assert property (
		run_lamp_o == run_o && halt_lamp_o == !run_o)
		else $error("lamps disagree with run state");
	chk_pwron_hold: assert property (
		$fell(rst_i) |-> (machine_reset_o && !run_o) [*8]
		##[1:PW_HI] (run_o && !machine_reset_o))
		else $error("power-on reset sequence wrong");
	chk_rtc_sets: assert property (
		$rose(flag_int_o) |-> istat_o[`ISTAT_RTC])
		else $error("timer flag without status bit");
	chk_pf_sets: assert property (
		$rose(flag_pf_o) |-> istat_o[`ISTAT_HALT])
		else $error("power flag without status bit");
	chk_reset_sw: assert property (
		sw_reset_i [*8] |-> machine_reset_o && io_reset_o && !run_o)
		else $error("reset switch not obeyed");
	chk_step_run: assert property (
		sw_step_i [*8] |-> run_o && istat_o[`ISTAT_HALT])
		else $error("step switch not obeyed");
	chk_sense_copy: assert property (
		sense_cmd |=> sense_load_o)
		else $error("sense copy missing");
	chk_sense_only: assert property (
		!sense_cmd |=> !sense_load_o)
		else $error("sense copy without command");
	cover property ($fell(machine_reset_o));
	cover property (sense_load_o);
	cover property ($rose(flag_int_o));
endmodule

bind run_halt_console_control run_halt_monitor #(
	.PWRON_CYCLES(PWRON_CYCLES)
) mon (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sw_step_i(sw_step_i),
	.sw_reset_i(sw_reset_i), .exec_valid_i(exec_valid_i),
	.exec_cmd_i(exec_cmd_i), .run_o(run_o), .run_lamp_o(run_lamp_o),
	.halt_lamp_o(halt_lamp_o), .machine_reset_o(machine_reset_o),
	.io_reset_o(io_reset_o), .istat_o(istat_o), .flag_int_o(flag_int_o),
	.flag_pf_o(flag_pf_o), .sense_load_o(sense_load_o)
);

// file: tb/testbench.sv
// Self-checking bench for the run/halt console control block.
`timescale 1ns/100ps
`include "run_halt_regs.svh"
module testbench;
	localparam int PWR = 20;
	localparam logic [11:0] DX [0:6] = '{12'h3c5, 12'h05a, 12'h0a7,
		12'h0c3, 12'h01e, 12'h096, 12'h000};
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic ce_i = 1'b1;
	logic halt_req_i = 1'b0;
	logic psel_i, penable_i, pwrite_i, exec_valid_i, cmd_done_i, er;
	logic pready_o, pslverr_o, irq_o, run_o, run_lamp_o, halt_lamp_o;
	logic machine_reset_o, io_reset_o, flag_int_o, flag_pf_o, sense_load_o;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic [15:0] sw_cmd_i, rom_data_i, exec_cmd_i, cmd_o;
	logic [11:0] l_reg_i, display_o;
	logic [7:0] paddr_i, m_reg_i, n_reg_i, abus_i, istat_ack_i, istat_o, sw;
	logic [6:0] sw_display_i;
	logic [3:0] sw_sense_i, sense_o;
	logic [1:0] flag_ack_i;
	logic [12:0] rtc_div_i;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	wire sw_run_i = sw[`SW_RUN];
	wire sw_step_i = sw[`SW_STEP];
	wire sw_intr_i = sw[`SW_INTR];
	wire sw_clock_i = sw[`SW_CLOCK];
	wire sw_reset_i = sw[`SW_RESET];
	wire sw_save_i = sw[`SW_SAVE];
	wire sw_panel_i = sw[`SW_PANEL];
	wire power_fail_i = sw[7];
	wire [15:0] cmd_reg_i = rom_data_i;
	run_halt_console_control #(.PWRON_CYCLES(PWR), .DEBOUNCE_CYCLES(2))
		DUT (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
		.psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o),
		.irq_o(irq_o), .sw_run_i(sw_run_i),
		.sw_step_i(sw_step_i), .sw_intr_i(sw_intr_i),
		.sw_clock_i(sw_clock_i), .sw_reset_i(sw_reset_i),
		.sw_save_i(sw_save_i), .sw_panel_i(sw_panel_i),
		.sw_sense_i(sw_sense_i), .sw_display_i(sw_display_i),
		.sw_cmd_i(sw_cmd_i), .power_fail_i(power_fail_i),
		.rtc_div_i(rtc_div_i), .rom_data_i(rom_data_i),
		.cmd_reg_i(cmd_reg_i), .l_reg_i(l_reg_i),
		.m_reg_i(m_reg_i), .n_reg_i(n_reg_i),
		.abus_i(abus_i), .exec_valid_i(exec_valid_i),
		.exec_cmd_i(exec_cmd_i), .cmd_done_i(cmd_done_i),
		.halt_req_i(halt_req_i), .istat_ack_i(istat_ack_i),
		.flag_ack_i(flag_ack_i), .run_o(run_o),
		.run_lamp_o(run_lamp_o), .halt_lamp_o(halt_lamp_o),
		.machine_reset_o(machine_reset_o),
		.io_reset_o(io_reset_o), .cmd_o(cmd_o),
		.display_o(display_o), .istat_o(istat_o),
		.flag_int_o(flag_int_o), .flag_pf_o(flag_pf_o),
		.sense_o(sense_o), .sense_load_o(sense_load_o)
	);
	console_model con (.clk_i(clk_sys_i), .sw_o(sw));
	always #4 clk_sys_i = ~clk_sys_i;
	task wt(input int k);
		repeat (k) @(posedge clk_sys_i);
	endtask
	task ck(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		wt(1);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		wt(1);
		penable_i <= 1'b1;
		do begin
			wt(1);
			k++;
		end while (pready_o !== 1'b1 && k < 40);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (k >= 40)
			ck(0, 1);
	endtask
	task exec(input logic [15:0] c);
		exec_valid_i <= 1'b1;
		exec_cmd_i <= c;
		wt(1);
		exec_valid_i <= 1'b0;
	endtask
	task ack(input logic [7:0] s, input logic [1:0] f);
		istat_ack_i <= s;
		flag_ack_i <= f;
		wt(1);
		istat_ack_i <= 8'h00;
		flag_ack_i <= 2'b00;
		wt(1);
	endtask
	task waitf;
		n = 0;
		while (flag_int_o !== 1'b1 && n < 60) begin
			wt(1);
			n++;
		end
	endtask
	task done1;
		cmd_done_i <= 1'b1;
		wt(1);
		cmd_done_i <= 1'b0;
		wt(2);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			print_verdict;
		end
	end
	initial begin
		{psel_i, penable_i, pwrite_i, exec_valid_i, cmd_done_i} = 5'h00;
		{paddr_i, pwdata_i, exec_cmd_i, istat_ack_i, flag_ack_i} = '0;
		{sw_cmd_i, rom_data_i} = {16'h5aa5, 16'hc31e};
		{l_reg_i, m_reg_i, n_reg_i, abus_i} = {12'h3c5, 24'h5aa796};
		{sw_display_i, sw_sense_i, rtc_div_i} = {7'h00, 4'ha, 13'd40};
		wt(16);
		rst_i <= 1'b0;
		wt(2);
		ck({machine_reset_o, run_o}, 2'b10);
		n = 2;
		while (machine_reset_o !== 1'b0 && n < 99) begin
			wt(1);
			n++;
		end
		ck(n >= PWR - 1 && n <= PWR + 3, 1);
		wt(2);
		ck({run_o, run_lamp_o, halt_lamp_o}, 3'b110);
		ck({flag_pf_o, istat_o[`ISTAT_HALT]}, 2'b11);
		apb(0, `REG_CTRL, 0);
		ck(rd, 1);
		apb(0, `REG_IRQ_STAT, 0);
		ck(rd[`EV_RESTART], 1);
		apb(0, 8'h20, 0);
		ck({er, rd[30:0]}, 32'h80000000);
		apb(1, `REG_STATE, 0);
		ck(er, 1);
		exec(`CMD_RTC_OFF);
		ack(8'hff, 2'b11);
		apb(1, `REG_IRQ_CLR, 32'h1f);
		wt(90);
		ck({flag_int_o, istat_o[`ISTAT_RTC], irq_o}, 0);
		apb(1, `REG_IRQ_EN, 32'h1);
		rtc_div_i <= 13'd25;
		exec(`CMD_RTC_ON);
		waitf;
		ck(istat_o[`ISTAT_RTC], 1);
		ack(8'h04, 2'b01);
		waitf;
		ck(n >= 21 && n <= 26, 1);
		ck(irq_o, 1);
		apb(1, `REG_IRQ_EN, 0);
		wt(3);
		ck(irq_o, 0);
		apb(1, `REG_CTRL, 0);
		apb(0, `REG_CTRL, 0);
		ck(rd, 0);
		apb(1, `REG_IRQ_CLR, 32'h1f);
		apb(0, `REG_IRQ_STAT, 0);
		ck(rd, 0);
		con.press(`SW_RESET, 10);
		wt(12);
		ck({run_o, halt_lamp_o, io_reset_o}, 3'b010);
		apb(0, `REG_STATE, 0);
		ck(rd[4:0], 5'h02);
		for (int i = 0; i < 7; i++) begin
			sw_display_i <= 7'h01 << i;
			wt(10);
			ck(display_o, DX[i]);
		end
		ce_i <= 1'b0;
		sw_display_i <= 7'h01;
		wt(10);
		ck(display_o, 12'h000);
		ce_i <= 1'b1;
		wt(10);
		ck(display_o, DX[0]);
		con.tap(`SW_RUN);
		wt(10);
		ck(run_o, 0);
		apb(1, `REG_IRQ_CLR, 32'h1f);
		con.press(`SW_CLOCK, 4);
		wt(4);
		ck(run_o, 1);
		done1;
		ck(run_o, 0);
		apb(0, `REG_IRQ_STAT, 0);
		ck(rd[`EV_HALTED], 1);
		con.press(`SW_RUN, 4);
		wt(4);
		done1;
		ck(run_o, 1);
		con.press(`SW_CLOCK, 4);
		wt(4);
		ck(run_o, 1);
		done1;
		ck(run_o, 0);
		con.press(`SW_INTR, 4);
		wt(4);
		ck({run_o, istat_o[`ISTAT_CONSOLE]}, 2'b11);
		con.press(`SW_RESET, 8);
		ack(8'hff, 2'b11);
		con.press(`SW_STEP, 12);
		ck({run_o, istat_o[`ISTAT_HALT]}, 2'b11);
		con.set_sw(`SW_PANEL, 1'b1);
		wt(10);
		ck(cmd_o, 16'h5aa5);
		con.set_sw(`SW_PANEL, 1'b0);
		wt(10);
		ck(cmd_o, 16'hc31e);
		exec(`CMD_SENSE);
		wt(1);
		ck({sense_load_o, sense_o}, 5'h1a);
		con.set_sw(`SW_SAVE, 1'b1);
		wt(30);
		ck({machine_reset_o, run_o}, 2'b10);
		con.set_sw(`SW_SAVE, 1'b0);
		wt(12);
		ck(machine_reset_o, 0);
		con.press(`SW_RUN, 4);
		ack(8'h80, 2'b10);
		con.set_sw(7, 1'b1);
		wt(8);
		ck({run_o, flag_pf_o, istat_o[`ISTAT_HALT]}, 3'b111);
		halt_req_i <= 1'b1;
		wt(4);
		halt_req_i <= 1'b0;
		wt(4);
		ck({run_o, machine_reset_o}, 2'b01);
		print_verdict;
	end
endmodule
